// >>> include/afo_pkg.sv
// Constants, types and helpers for the converter output formatter
// Contract
// - Format input high gives two's complement, low gives offset binary.
// - Two's complement equals offset binary with only the top bit inverted.
// - Offset-binary codes saturate at all ones above range, all zeros below; never wrap.
// - Data pins driven while active-low enable is low, released while high.
// - Range flag low inside full scale, high above or below it.
// - Range flag travels the same pipeline as the data word.
// - Range flag stays high across consecutive out-of-range samples.
// - Sample on rising edge, present on falling edge 4.5 periods later.
// - Output word is registered and steady between update edges.
// - Conversion runs only while both sleep inputs are low.
// - Full sleep recovers in about 800 us, core-only sleep in about 2 us.
// - Sleep discards words in flight; valid words return after full latency.
package afo_pkg;
  localparam int CODE_W = 12;
  localparam int IN_W = 14;
  localparam int PIPE_STAGES = 4;
  localparam logic signed [IN_W-1:0] CODE_HI = 14'sh07ff;
  localparam logic signed [IN_W-1:0] CODE_LO = -14'sh0800;
  localparam logic [CODE_W-1:0] CODE_ALL_ONES = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_ALL_ZEROS = 12'h000;
  localparam logic [CODE_W-1:0] CODE_MSB = 12'h800;

  localparam int CLOCK_MHZ = 40;
  localparam int FULL_WAKE_US = 800;
  localparam int CORE_WAKE_US = 2;
  localparam int WAKE_W = 16;
  localparam int FULL_WAKE_CYC = FULL_WAKE_US * CLOCK_MHZ;
  localparam logic [WAKE_W-1:0] CORE_WAKE_CYC = WAKE_W'(CORE_WAKE_US * CLOCK_MHZ);

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0c;
  localparam int CTRL_SW_SLEEP = 0;
  localparam int ST_AWAKE = 0;
  localparam int ST_RANGE = 1;
  localparam int ST_DEEP = 2;
  localparam int INT_W = 2;
  localparam int EV_RANGE = 0;
  localparam int EV_WAKE = 1;

  typedef enum logic [2:0] {
    PWR_AWAKE = 3'b001,
    PWR_SLEEP = 3'b010,
    PWR_WAKE = 3'b100
  } afo_pwr_t;

  // Offset-binary code of a raw sample, clamped, plus the range flag
  function automatic logic [CODE_W:0] afo_clamp(input logic signed [IN_W-1:0] raw);
    logic [CODE_W:0] r;
    r = {1'b0, raw[CODE_W-1:0] ^ CODE_MSB};
    if (raw > CODE_HI) begin
      r = {1'b1, CODE_ALL_ONES};
    end else if (raw < CODE_LO) begin
      r = {1'b1, CODE_ALL_ZEROS};
    end
    return r;
  endfunction
endpackage

// >>> include/afo_pipe_if.sv
// Interface between the sampling front and the output pipeline
`timescale 1ns/100ps
interface afo_pipe_if;
  import afo_pkg::*;
  logic [CODE_W-1:0] in_word;
  logic in_flag;
  logic in_valid;
  logic flush;
  logic oe_n;
  logic [CODE_W-1:0] out_word;
  logic [CODE_W-1:0] out_oe;
  logic out_flag;
  logic out_valid;
  modport front (output in_word, in_flag, in_valid, flush, oe_n, input out_word, out_oe, out_flag, out_valid);
  modport pipe (input in_word, in_flag, in_valid, flush, oe_n, output out_word, out_oe, out_flag, out_valid);
endinterface

// >>> hdl/afo_pipe.sv
// Output pipeline: rising-edge delay stages then a falling-edge output latch
`timescale 1ns/100ps
module afo_pipe
  import afo_pkg::*;
#(
  parameter int STAGES = PIPE_STAGES
) (
  input wire logic clock,
  input wire logic sys_rst,
  afo_pipe_if.pipe p
);
  typedef struct packed {
    logic [STAGES-1:0][CODE_W-1:0] word;
    logic [STAGES-1:0] flag;
    logic [STAGES-1:0] valid;
  } afo_stage_t;

  typedef struct packed {
    logic [CODE_W-1:0] word;
    logic [CODE_W-1:0] oe;
    logic flag;
    logic valid;
  } afo_out_t;

  afo_stage_t st_ff, nxt_st;
  afo_out_t out_ff, nxt_out;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.word = {st_ff.word[STAGES-2:0], p.in_word};
    nxt_st.flag = {st_ff.flag[STAGES-2:0], p.in_flag};
    nxt_st.valid = {st_ff.valid[STAGES-2:0], p.in_valid};
    if (p.flush) begin
      nxt_st = '0;
    end
    nxt_out.word = st_ff.word[STAGES-1];
    nxt_out.flag = st_ff.flag[STAGES-1];
    nxt_out.valid = st_ff.valid[STAGES-1];
    nxt_out.oe = {CODE_W{~p.oe_n}};
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Falling edge gives the half period of the 4.5 cycle latency
  always_ff @(negedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign p.out_word = out_ff.word;
  assign p.out_oe = out_ff.oe;
  assign p.out_flag = out_ff.flag;
  assign p.out_valid = out_ff.valid;
endmodule

// >>> hdl/afo_top.sv
// Converter output formatter: coding, clamp, range flag, sleep control, register slave
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
module afo_top
  import afo_pkg::*;
#(
  parameter logic [WAKE_W-1:0] FULL_WAKE_CYCLES = WAKE_W'(FULL_WAKE_CYC)
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic signed [IN_W-1:0] sample_code,
  input wire logic format_select,
  input wire logic output_enable_n,
  input wire logic full_sleep,
  input wire logic core_only_sleep,
  output logic [CODE_W-1:0] data_out,
  output logic [CODE_W-1:0] data_oe,
  output logic range_exceeded_flag,
  output logic word_valid,
  output logic irq,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  typedef struct packed {
    afo_pwr_t pwr;
    logic deep;
    logic [WAKE_W-1:0] wake_cnt;
    logic [CODE_W-1:0] s0_word;
    logic s0_flag;
    logic s0_valid;
    logic pend;
    logic pend_wr;
    logic [7:0] pend_addr;
    logic hready;
    logic [31:0] hrdata;
    logic sw_sleep;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic irq;
  } afo_state_t;

  afo_state_t st_ff, nxt_st;
  afo_pipe_if pif();

  logic [CODE_W:0] clamped;
  logic sleep_req;
  logic [INT_W-1:0] ev_set;
  logic [INT_W-1:0] ev_clr;

  always_comb begin
    nxt_st = st_ff;
    clamped = afo_clamp(sample_code);
    sleep_req = full_sleep | core_only_sleep | st_ff.sw_sleep;
    ev_set = '0;
    ev_clr = '0;

    unique case (st_ff.pwr)
      PWR_AWAKE: begin
        if (sleep_req) begin
          nxt_st.pwr = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (!sleep_req) begin
          nxt_st.pwr = PWR_WAKE;
          nxt_st.wake_cnt = st_ff.deep ? FULL_WAKE_CYCLES : CORE_WAKE_CYC;
        end
      end
      PWR_WAKE: begin
        if (sleep_req) begin
          nxt_st.pwr = PWR_SLEEP;
        end else if (st_ff.wake_cnt <= WAKE_W'(1)) begin
          nxt_st.pwr = PWR_AWAKE;
          ev_set[EV_WAKE] = 1'b1;
        end else begin
          nxt_st.wake_cnt = st_ff.wake_cnt - WAKE_W'(1);
        end
      end
      default: nxt_st.pwr = PWR_SLEEP;
    endcase
    // A full sleep seen in the sleep state forces the long recovery; a sleep request during recovery takes full_sleep anew
    if (sleep_req && st_ff.pwr != PWR_SLEEP) begin
      nxt_st.deep = full_sleep;
    end else if (st_ff.pwr == PWR_SLEEP && full_sleep) begin
      nxt_st.deep = 1'b1;
    end

    // Capture on the rising edge; coding chosen here
    nxt_st.s0_word = format_select ? (clamped[CODE_W-1:0] ^ CODE_MSB) : clamped[CODE_W-1:0];
    nxt_st.s0_flag = clamped[CODE_W];
    nxt_st.s0_valid = (st_ff.pwr == PWR_AWAKE) && !sleep_req;
    if (clamped[CODE_W] && !st_ff.s0_flag && nxt_st.s0_valid) begin
      ev_set[EV_RANGE] = 1'b1;
    end

    // Bus slave: one wait state so a read always sees the previous write
    nxt_st.hready = 1'b1;
    nxt_st.pend = 1'b0;
    if (st_ff.pend) begin
      if (st_ff.pend_wr) begin
        unique case (st_ff.pend_addr)
          REG_CTRL: nxt_st.sw_sleep = hwdata[CTRL_SW_SLEEP];
          REG_INT_STAT: ev_clr = hwdata[INT_W-1:0];
          REG_INT_MASK: nxt_st.int_mask = hwdata[INT_W-1:0];
          default: ;
        endcase
        nxt_st.hrdata = '0;
      end else begin
        unique case (st_ff.pend_addr)
          REG_CTRL: nxt_st.hrdata = 32'(st_ff.sw_sleep);
          REG_STATUS: nxt_st.hrdata = 32'({st_ff.deep, st_ff.s0_flag, st_ff.pwr == PWR_AWAKE});
          REG_INT_STAT: nxt_st.hrdata = 32'(st_ff.int_stat);
          REG_INT_MASK: nxt_st.hrdata = 32'(st_ff.int_mask);
          default: nxt_st.hrdata = '0;
        endcase
      end
    end else if (hsel && htrans[1] && hready) begin
      nxt_st.pend = 1'b1;
      nxt_st.pend_wr = hwrite;
      nxt_st.pend_addr = {haddr[7:2], 2'b00};
      nxt_st.hready = 1'b0;
    end

    // Set wins over a clear in the same cycle
    nxt_st.int_stat = (st_ff.int_stat & ~ev_clr) | ev_set;
    nxt_st.irq = |(nxt_st.int_stat & st_ff.int_mask);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '{pwr: PWR_AWAKE, hready: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pif.in_word = st_ff.s0_word;
  assign pif.in_flag = st_ff.s0_flag;
  assign pif.in_valid = st_ff.s0_valid;
  assign pif.flush = sleep_req;
  assign pif.oe_n = output_enable_n;

  afo_pipe #(
    .STAGES(PIPE_STAGES)
  ) u_pipe (
    .clock(clock),
    .sys_rst(sys_rst),
    .p(pif.pipe)
  );

  assign data_out = pif.out_word;
  assign data_oe = pif.out_oe;
  assign range_exceeded_flag = pif.out_flag;
  assign word_valid = pif.out_valid;
  assign irq = st_ff.irq;
  assign hreadyout = st_ff.hready;
  assign hrdata = st_ff.hrdata;
  assign hresp = 1'b0;
endmodule

// >>> verification/afo_props.sv
// Checker for output coding, range flag, output enable and sleep timing
`timescale 1ns/100ps
module afo_props
  import afo_pkg::*;
#(
  parameter logic [WAKE_W-1:0] FULL_WAKE_CYCLES = WAKE_W'(FULL_WAKE_CYC)
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic signed [IN_W-1:0] sample_code,
  input wire logic format_select,
  input wire logic output_enable_n,
  input wire logic full_sleep,
  input wire logic core_only_sleep,
  input wire logic [CODE_W-1:0] data_out,
  input wire logic [CODE_W-1:0] data_oe,
  input wire logic range_exceeded_flag,
  input wire logic word_valid
);
  logic [IN_W:0] hist_ff [5];
  // Wide enough for the long recovery at its full default length
  logic [WAKE_W-1:0] quiet_ff;
  logic slept_ff, full_ff;
  logic [CODE_W:0] ew;
  int lim;
  wire slp = full_sleep | core_only_sleep;
  always_comb begin
    ew = {1'b0, hist_ff[4][CODE_W-1:0] ^ CODE_MSB};
    if ($signed(hist_ff[4][IN_W-1:0]) > CODE_HI) ew = 13'h1fff;
    else if ($signed(hist_ff[4][IN_W-1:0]) < CODE_LO) ew = 13'h1000;
    if (hist_ff[4][IN_W]) ew[CODE_W-1] = ~ew[CODE_W-1];
    lim = full_ff ? int'(FULL_WAKE_CYCLES) : 80;
  end
  // Wake time is measured as idle cycles between sleep release and the first valid word
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      quiet_ff <= '0;
      slept_ff <= 1'b0;
      full_ff <= 1'b0;
    end else begin
      hist_ff[0] <= {format_select, sample_code};
      for (int i = 1; i < 5; i++) hist_ff[i] <= hist_ff[i-1];
      quiet_ff <= (slp || word_valid) ? '0 : quiet_ff + WAKE_W'(1);
      slept_ff <= slp | (slept_ff & ~word_valid);
      full_ff <= full_sleep | (full_ff & ~word_valid);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_run; word_valid && !slp ##1 !slp; endsequence
  sequence s_over2; (word_valid && ew[CODE_W]) [*2]; endsequence
  property p_word; word_valid |-> data_out == ew[CODE_W-1:0]; endproperty
  property p_flag; word_valid |-> range_exceeded_flag == ew[CODE_W]; endproperty
  property p_stay; s_over2 |-> range_exceeded_flag && $stable(range_exceeded_flag); endproperty
  property p_oe; !$past(sys_rst) |-> data_oe == {CODE_W{~output_enable_n}}; endproperty
  property p_sleep; slp [*2] |-> !word_valid; endproperty
  property p_run; s_run |-> word_valid; endproperty
  property p_wake_min; $rose(word_valid) && slept_ff |-> quiet_ff >= lim; endproperty
  property p_wake_max; slept_ff && !slp |-> quiet_ff <= lim + 12; endproperty
  a_word: assert property (p_word) else $error("data word mismatch");
  a_flag: assert property (p_flag) else $error("range flag mismatch");
  a_stay: assert property (p_stay) else $error("range flag dropped");
  a_oe: assert property (p_oe) else $error("enable mismatch");
  a_sleep: assert property (p_sleep) else $error("valid during sleep");
  a_run: assert property (p_run) else $error("valid lost while awake");
  a_wake_min: assert property (p_wake_min) else $error("wake too early");
  a_wake_max: assert property (p_wake_max) else $error("wake too late");
endmodule
bind afo_top afo_props #(.FULL_WAKE_CYCLES(FULL_WAKE_CYCLES)) u_props (.clock, .sys_rst, .sample_code, .format_select,
  .output_enable_n, .full_sleep, .core_only_sleep, .data_out, .data_oe, .range_exceeded_flag, .word_valid);

// >>> verification/afo_capture.sv
// Capture-side model: resolves the data pins and latches valid words
`timescale 1ns/100ps
module afo_capture
  import afo_pkg::*;
(
  input wire logic clock,
  input wire logic [CODE_W-1:0] data_out,
  input wire logic [CODE_W-1:0] data_oe,
  input wire logic range_exceeded_flag,
  input wire logic word_valid,
  output logic [CODE_W:0] cap_word
);
  logic [CODE_W-1:0] last_ff = 12'h000;
  logic [CODE_W-1:0] pins;
  // Released pins show the inverse of their last level, so a stale word cannot pass
  assign pins = (data_oe & data_out) | (~data_oe & ~last_ff);
  // Plain always, since the pin history keeps a start level from its declaration
  always @(posedge clock) begin
    last_ff <= pins;
    if (word_valid) begin
      cap_word <= {range_exceeded_flag, pins};
    end
  end
endmodule

// >>> verification/tb_adc_output_formatter.sv
// Bench for the converter output formatter
`timescale 1ns/100ps
module tb_adc_output_formatter;
  import afo_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, format_select = 1'b0, output_enable_n = 1'b0;
  logic full_sleep = 1'b0, core_only_sleep = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic signed [IN_W-1:0] sample_code = 14'sh0000;
  logic [CODE_W-1:0] data_out, data_oe;
  logic range_exceeded_flag, word_valid, irq, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [CODE_W:0] cap_word, ew;
  logic [CODE_W:0] q [$];
  logic [15:0] lf = 16'h7457;
  logic signed [IN_W-1:0] tbl [8] = '{14'sh07ff, 14'sh0800, 14'sh1fff, 14'sh3800, 14'sh37ff, 14'sh2000, 14'sh0000,
    14'sh0400};
  int err_total = 0, compares = 0, n;
  afo_top #(.FULL_WAKE_CYCLES(16'h0014)) uut (.clock(clock), .sys_rst(sys_rst), .sample_code(sample_code),
    .format_select(format_select), .output_enable_n(output_enable_n), .full_sleep(full_sleep),
    .core_only_sleep(core_only_sleep), .data_out(data_out), .data_oe(data_oe), .range_exceeded_flag(range_exceeded_flag),
    .word_valid(word_valid), .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  afo_capture u_cap (.clock(clock), .data_out(data_out), .data_oe(data_oe), .range_exceeded_flag(range_exceeded_flag),
    .word_valid(word_valid), .cap_word(cap_word));
  initial begin
    forever #12.5 clock = ~clock;
  end
  function automatic logic [12:0] expw(input logic signed [13:0] s, input logic f);
    logic [12:0] r;
    r = {1'b0, s[11:0] ^ 12'h800};
    if (s > 14'sh07ff) r = 13'h1fff;
    else if (s < 14'sh3800) r = 13'h1000;
    if (f) r[11] = ~r[11];
    return r;
  endfunction
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", 32'h0, hresp);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    ahb(1'b0, a, 32'h0);
    check("register", e, rd & m);
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic feed(input int k);
    repeat (k) begin
      lf = lfsr_next(lf);
      sample_code <= {{2{lf[11]}}, lf[11:0]};
      format_select <= lf[12];
      @(posedge clock);
    end
  endtask
  // Expectation noted at the sampling edge; the monitor takes it back five edges later
  always @(posedge clock) q.push_back(expw(sample_code, format_select));
  always @(posedge clock) begin
    #1;
    if (q.size() > 5) begin
      ew = q.pop_front();
      if (word_valid === 1'b1 && data_oe === 12'hfff) check("word", ew, cap_word);
    end
  end
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rchk(REG_INT_MASK, 32'h0, 32'hffffffff);
    rchk(REG_STATUS, 32'h1, 32'h1);
    ahb(1'b1, 8'h10, 32'hffffffff);
    rchk(8'h10, 32'h0, 32'hffffffff);
    $display("Test registers done");
    feed(40);
    for (int i = 0; i < 16; i++) begin
      sample_code <= tbl[i>>1];
      format_select <= i[0];
      @(posedge clock);
    end
    repeat (8) @(posedge clock);
    $display("Test coding done");
    check("irq", 32'h0, irq);
    rchk(REG_INT_STAT, 32'h1, 32'h1);
    ahb(1'b1, REG_INT_MASK, 32'h1);
    repeat (2) @(posedge clock);
    check("irq", 32'h1, irq);
    ahb(1'b1, REG_INT_STAT, 32'h1);
    repeat (2) @(posedge clock);
    check("irq", 32'h0, irq);
    $display("Test interrupt done");
    output_enable_n <= 1'b1;
    repeat (3) @(posedge clock);
    check("enable", 32'h0, data_oe);
    output_enable_n <= 1'b0;
    repeat (3) @(posedge clock);
    check("enable", 32'hfff, data_oe);
    $display("Test enable done");
    for (int k = 0; k < 2; k++) begin
      if (k == 1) full_sleep <= 1'b1;
      else core_only_sleep <= 1'b1;
      repeat (10) @(posedge clock);
      check("valid", 32'h0, word_valid);
      if (k == 0) begin
        rchk(REG_STATUS, 32'h0, 32'h1);
        ahb(1'b1, REG_CTRL, 32'h1);
        rchk(REG_CTRL, 32'h1, 32'h1);
        ahb(1'b1, REG_CTRL, 32'h0);
      end
      full_sleep <= 1'b0;
      core_only_sleep <= 1'b0;
      n = 0;
      while (word_valid !== 1'b1 && n < 300) begin
        @(posedge clock);
        n++;
      end
      check("wake", 32'h1, n >= (k ? 20 : 80) && n <= (k ? 32 : 92));
      feed(20);
    end
    rchk(REG_INT_STAT, 32'h2, 32'h2);
    rchk(REG_STATUS, 32'h5, 32'h7);
    $display("Test sleep done");
    close_out();
  end
endmodule
